// File: hw/ebc_pkg.sv
// Shared constants and types of the external bus control block
`default_nettype none

package ebc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Processor mode control register layout
  // ----------------------------------------------------------------
  localparam logic [7:0] PMC_RESET   = 8'h00;
  localparam int         PMC_STB_SEL = 2;  // 1: split byte store strobes
  localparam int         PMC_CLK_DIS = 7;  // 1: bus clock pin floats

  // ----------------------------------------------------------------
  // Access areas and bus cycle lengths in bus clock cycles
  // ----------------------------------------------------------------
  localparam logic [1:0] AREA_SFR = 2'h0;
  localparam logic [1:0] AREA_INT = 2'h1;
  localparam logic [1:0] AREA_EXT = 2'h2;

  localparam logic [1:0] CYC_SFR     = 2'h2;
  localparam logic [1:0] CYC_INT     = 2'h1;
  localparam logic [1:0] CYC_EXT_NW  = 2'h1;
  localparam logic [1:0] CYC_EXT_W   = 2'h2;
  localparam logic [1:0] CYC_EXT_MUX = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              write;    // 1: write, 0: read
    logic              word;     // 1: 16-bit access
    logic [1:0]        area;     // AREA_*
    logic [1:0]        cs_idx;   // chip select of an external access
    logic              mux;      // multiplexed bus space
  } ebc_req_s;

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_HOLD} ebc_state_e;

endpackage : ebc_pkg

`default_nettype wire

// File: hw/ebc_top.sv
// External bus control: strobes, address latch, ready waits, hold arbitration
// Functional notes
// - 16-bit bus: mode bit 2 picks strobe set
// - Reset selects read/store/byte-high-enable set
// - Mode writes only when protect bit set
// - Split mode: low/high stores per byte lane
// - Combined mode: byte-high-enable with A0 marks lanes
// - Ready low on bus clock fall waits
// - Ready honoured only when area wait bit zero
// - Ready wait holds all bus outputs
// - Ready ignored right before software wait
// - Hold request enters hold after access
// - Priority: hold, transfer engine, core
// - Hold floats bus, grants, stops watchdog
// - Special area: strobes driven, selects high
// - Internal memory: address kept, strobes high
// - Mode bit 7 floats bus clock pin
// - Area wait bit zero inserts wait state outside multiplexed space
`default_nettype none

module ebc_top (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // Link pins
  input  wire logic                         bclk_in,
  input  wire logic                         rdy_n,
  input  wire logic                         hold_n,
  input  wire logic                         byte_pin,
  input  wire logic [ebc_pkg::DATA_W-1:0]   data_in,
  // Configuration
  input  wire logic                         pmc_wr,
  input  wire logic [7:0]                   pmc_wdata,
  input  wire logic                         protect_pm,
  input  wire logic [3:0]                   cs_wait,
  output logic      [7:0]                   pmc_q,
  // Requesters
  input  wire logic                         core_valid,
  input  wire ebc_pkg::ebc_req_s            core_req,
  output logic                              core_done,
  input  wire logic                         dma_valid,
  input  wire ebc_pkg::ebc_req_s            dma_req,
  output logic                              dma_done,
  output logic      [ebc_pkg::DATA_W-1:0]   rdata,
  // Bus pins
  output logic      [ebc_pkg::ADDR_W-1:0]   addr_out,
  output logic                              addr_oe_n,
  output logic      [ebc_pkg::DATA_W-1:0]   data_out,
  output logic                              data_oe_n,
  output logic                              rd_n,
  output logic                              wr_n,
  output logic                              byte_high_enable_n,
  output logic                              low_byte_store_strobe_n,
  output logic                              high_byte_store_strobe_n,
  output logic      [3:0]                   cs_n,
  output logic                              ctrl_oe_n,
  output logic                              ale,
  output logic                              bus_grant_out_n,
  output logic                              bclk_out,
  output logic                              bclk_oe_n,
  // Hold side effects
  output logic                              port_low_float,
  output logic                              watchdog_stop
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 4 + ebc_pkg::DATA_W;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic          bclk_d_reg;

  // Two flops per pin, plus a third on the bus clock for edge detect; the first stage feeds no logic
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg  <= '1;
      sync2_reg  <= '1;
      bclk_d_reg <= 1'b1;
    end else begin
      sync1_reg  <= {bclk_in, rdy_n, hold_n, byte_pin, data_in};
      sync2_reg  <= sync1_reg;
      bclk_d_reg <= sync2_reg[SW-1];
    end
  end

  logic                       bclk_s;
  logic                       rdy_s_n;
  logic                       hold_req;
  logic                       bus8;
  logic [ebc_pkg::DATA_W-1:0] din_s;
  logic                       bclk_fall;

  // All bus state moves on the falling bus clock edge
  assign bclk_s    = sync2_reg[SW-1];
  assign rdy_s_n   = sync2_reg[SW-2];
  assign hold_req  = ~sync2_reg[SW-3];
  assign bus8      = sync2_reg[SW-4];
  assign din_s     = sync2_reg[ebc_pkg::DATA_W-1:0];
  assign bclk_fall = bclk_d_reg & ~bclk_s;

  // ----------------------------------------------------------------
  // Processor mode control register
  // ----------------------------------------------------------------
  logic [7:0] pmc_reg;
  logic [7:0] pmc_next;

  // Unprotected writes are dropped so a stray store cannot flip modes
  always_comb begin
    pmc_next = pmc_reg;
    if (pmc_wr && protect_pm) begin
      pmc_next = pmc_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pmc_reg <= ebc_pkg::PMC_RESET;
    end else begin
      pmc_reg <= pmc_next;
    end
  end

  assign pmc_q = pmc_reg;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] cyc_len(input ebc_pkg::ebc_req_s r, input logic [3:0] w);
    logic [1:0] n;
    n = ebc_pkg::CYC_INT;
    if (r.area == ebc_pkg::AREA_SFR) begin
      n = ebc_pkg::CYC_SFR;
    end else if (r.area == ebc_pkg::AREA_EXT) begin
      if (r.mux) begin
        n = ebc_pkg::CYC_EXT_MUX;
      end else if (w[r.cs_idx]) begin
        n = ebc_pkg::CYC_EXT_NW;
      end else begin
        n = ebc_pkg::CYC_EXT_W;
      end
    end
    return n;
  endfunction : cyc_len

  logic split;
  assign split = pmc_reg[ebc_pkg::PMC_STB_SEL] & ~bus8;

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  ebc_pkg::ebc_state_e        state_reg, state_next;
  ebc_pkg::ebc_req_s          cur_reg, cur_next;
  logic                       own_dma_reg, own_dma_next;
  logic [1:0]                 cnt_reg, cnt_next;
  logic                       first_reg, first_next;
  logic [ebc_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic                       bhe_reg, bhe_next;
  logic [ebc_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic                       cdone_reg, cdone_next;
  logic                       ddone_reg, ddone_next;
  logic                       rdy_ok;
  ebc_pkg::ebc_req_s          pick;

  // Ready counts only in an external cycle whose area wait bit is zero
  assign rdy_ok = (cur_reg.area == ebc_pkg::AREA_EXT) && !cs_wait[cur_reg.cs_idx];
  assign pick   = dma_valid ? dma_req : core_req;

  always_comb begin
    state_next   = state_reg;
    cur_next     = cur_reg;
    own_dma_next = own_dma_reg;
    cnt_next     = cnt_reg;
    first_next   = first_reg;
    addr_next    = addr_reg;
    bhe_next     = bhe_reg;
    rdata_next   = rdata_reg;
    cdone_next   = 1'b0;
    ddone_next   = 1'b0;
    if (bclk_fall) begin
      case (state_reg)
        ebc_pkg::ST_IDLE: begin
          if (hold_req) begin
            state_next = ebc_pkg::ST_HOLD;
          end else if (dma_valid || core_valid) begin
            state_next   = ebc_pkg::ST_BUSY;
            cur_next     = pick;
            own_dma_next = dma_valid;
            cnt_next     = cyc_len(pick, cs_wait);
            first_next   = 1'b1;
            if (pick.area != ebc_pkg::AREA_INT) begin
              addr_next = pick.addr;
              bhe_next  = bus8 | split | ~(pick.word | pick.addr[0]);
            end
          end
        end
        ebc_pkg::ST_BUSY: begin
          first_next = 1'b0;
          if (cnt_reg > 2'h1) begin
            cnt_next = cnt_reg - 2'h1;
          end else if (rdy_ok && !rdy_s_n) begin
            state_next = ebc_pkg::ST_BUSY;
          end else begin
            cdone_next = ~own_dma_reg;
            ddone_next = own_dma_reg;
            if (!cur_reg.write) begin
              rdata_next = din_s;
            end
            state_next = hold_req ? ebc_pkg::ST_HOLD : ebc_pkg::ST_IDLE;
          end
        end
        ebc_pkg::ST_HOLD: begin
          if (!hold_req) begin
            state_next = ebc_pkg::ST_IDLE;
          end
        end
        default: begin
          state_next = ebc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= ebc_pkg::ST_IDLE;
      cur_reg     <= '0;
      own_dma_reg <= 1'b0;
      cnt_reg     <= 2'h0;
      first_reg   <= 1'b0;
      addr_reg    <= '0;
      bhe_reg     <= 1'b1;
      rdata_reg   <= '0;
      cdone_reg   <= 1'b0;
      ddone_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cur_reg     <= cur_next;
      own_dma_reg <= own_dma_next;
      cnt_reg     <= cnt_next;
      first_reg   <= first_next;
      addr_reg    <= addr_next;
      bhe_reg     <= bhe_next;
      rdata_reg   <= rdata_next;
      cdone_reg   <= cdone_next;
      ddone_reg   <= ddone_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  logic busy;
  logic act;
  logic held;

  // Internal memory cycles keep the pins quiet to save switching
  assign busy = (state_reg == ebc_pkg::ST_BUSY);
  assign act  = busy && (cur_reg.area != ebc_pkg::AREA_INT);
  assign held = (state_reg == ebc_pkg::ST_HOLD);

  assign rd_n                     = ~(act && !cur_reg.write);
  assign wr_n                     = ~(act && cur_reg.write && !split);
  assign low_byte_store_strobe_n  = ~(act && cur_reg.write && split && (cur_reg.word | ~cur_reg.addr[0]));
  assign high_byte_store_strobe_n = ~(act && cur_reg.write && split && (cur_reg.word | cur_reg.addr[0]));
  assign byte_high_enable_n       = bhe_reg;
  assign addr_out                 = addr_reg;
  assign data_out                 = cur_reg.wdata;
  assign data_oe_n                = ~(act && cur_reg.write && !held);

  // One select per external chip select index, generated rather than spelled out
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cs
      assign cs_n[gi] = ~(busy && cur_reg.area == ebc_pkg::AREA_EXT && cur_reg.cs_idx == 2'(gi));
    end
  endgenerate

  // Latch pulse high in the second half of the first bus clock of a multiplexed cycle, falls with the clock
  assign ale = busy && first_reg && cur_reg.mux && (cur_reg.area == ebc_pkg::AREA_EXT) && bclk_s;

  assign addr_oe_n       = held;
  assign ctrl_oe_n       = held;
  assign bus_grant_out_n = ~held;
  assign port_low_float  = held;
  assign watchdog_stop   = held;

  // Resampled clock lags the pin by two system clocks
  assign bclk_out  = bclk_s;
  assign bclk_oe_n = pmc_reg[ebc_pkg::PMC_CLK_DIS];

  assign core_done = cdone_reg;
  assign dma_done  = ddone_reg;
  assign rdata     = rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_protect;
    pmc_wr && !protect_pm |=> $stable(pmc_reg);
  endproperty
  a_protect: assert property (p_protect) else $error("mode register changed while protected");

  property p_split_even;
    act && split && cur_reg.write && !cur_reg.word && !cur_reg.addr[0]
      |-> !low_byte_store_strobe_n && high_byte_store_strobe_n && wr_n;
  endproperty
  a_split_even: assert property (p_split_even) else $error("split even byte strobes wrong");

  property p_comb_odd;
    bclk_fall && state_reg == ebc_pkg::ST_IDLE && !hold_req && (dma_valid || core_valid) && !split && !bus8
      && !pick.word && pick.addr[0] && pick.area != ebc_pkg::AREA_INT |=> !byte_high_enable_n && addr_out[0];
  endproperty
  a_comb_odd: assert property (p_comb_odd) else $error("odd byte not marked");

  property p_rdy_hold;
    bclk_fall && busy && cnt_reg == 2'h1 && rdy_ok && !rdy_s_n
      |=> busy && $stable(addr_out) && $stable(cs_n) && $stable(rd_n) && !core_done && !dma_done;
  endproperty
  a_rdy_hold: assert property (p_rdy_hold) else $error("ready wait did not hold the bus");

  property p_rdy_ignored;
    bclk_fall && busy && cnt_reg == 2'h1 && !rdy_ok |=> (core_done || dma_done);
  endproperty
  a_rdy_ignored: assert property (p_rdy_ignored) else $error("ready honoured outside its area");

  property p_pre_wait;
    bclk_fall && busy && cnt_reg == 2'h2 |=> busy && cnt_reg == 2'h1;
  endproperty
  a_pre_wait: assert property (p_pre_wait) else $error("ready taken before software wait");

  property p_hold_enter;
    bclk_fall && state_reg == ebc_pkg::ST_IDLE && hold_req |=> !bus_grant_out_n && addr_oe_n && ctrl_oe_n;
  endproperty
  a_hold_enter: assert property (p_hold_enter) else $error("hold not granted");

  property p_priority;
    bclk_fall && state_reg == ebc_pkg::ST_IDLE && !hold_req && dma_valid && core_valid
      |=> busy && own_dma_reg;
  endproperty
  a_priority: assert property (p_priority) else $error("transfer engine lost priority");

  property p_internal;
    busy && cur_reg.area == ebc_pkg::AREA_INT |-> rd_n && wr_n && (&cs_n) && !ale && $stable(addr_out);
  endproperty
  a_internal: assert property (p_internal) else $error("internal cycle disturbed pins");

  property p_sfr;
    busy && cur_reg.area == ebc_pkg::AREA_SFR |-> (&cs_n) && !ale
      && (rd_n != (wr_n & low_byte_store_strobe_n & high_byte_store_strobe_n));
  endproperty
  a_sfr: assert property (p_sfr) else $error("special area pins wrong");

  property p_clk_pin;
    pmc_wr && protect_pm |=> bclk_oe_n == $past(pmc_wdata[ebc_pkg::PMC_CLK_DIS]);
  endproperty
  a_clk_pin: assert property (p_clk_pin) else $error("bus clock enable mismatch");

endmodule : ebc_top

`default_nettype wire

// File: testbench/ebc_far.sv
// Far-side model: bus clock, ready device, address latch, read data
`default_nettype none
module ebc_far (
  // Bus clock, ready and data toward the device
  output logic                             bclk_in,
  output logic                             rdy_n,
  output logic      [ebc_pkg::DATA_W-1:0]  data_in,
  // Strobes, selects and address from the device
  input  wire logic                        rd_n,
  input  wire logic                        wr_n,
  input  wire logic                        lbs_n,
  input  wire logic                        hbs_n,
  input  wire logic                        ale,
  input  wire logic [3:0]                  cs_n,
  input  wire logic [ebc_pkg::ADDR_W-1:0]  addr_out,
  // Bench commands
  input  wire logic [3:0]                  n_wait,
  input  wire logic                        stuck,
  output logic      [ebc_pkg::ADDR_W-1:0]  lat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left;
  logic       act;
  assign act = !(rd_n && wr_n && lbs_n && hbs_n);
  // --------------------------------------------------------------
  // Bus clock, phase unrelated to the system clock
  // --------------------------------------------------------------
  initial begin
    bclk_in = 1'b1;
    rdy_n = 1'b1;
    left = 4'h0;
    data_in = 16'h0;
    lat = 20'h0;
    #7;
    forever #100 bclk_in = ~bclk_in;
  end
  // Late by 20 ns so the device strobes are settled when sampled
  always @(negedge bclk_in) begin
    #20;
    if (!act) begin
      left = n_wait;
      rdy_n = !stuck;
    end else if (left != 4'h0) begin
      left = left - 4'h1;
      rdy_n = 1'b0;
    end else begin
      rdy_n = !stuck;
    end
  end
  // Released bus shows the inverse of the last value, never a held copy
  always @(rd_n or addr_out or cs_n)
    if (!rd_n && cs_n != 4'hf) data_in = addr_out[15:0] ^ 16'h5a5a;
    else data_in = ~data_in;
  // Address captured on the falling latch pulse
  always @(negedge ale) lat = addr_out;
endmodule : ebc_far
`default_nettype wire

// File: testbench/external_bus_control_tb.sv
// Self-checking bench of the external bus control block
`default_nettype none
module external_bus_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic              clk, rstn, bclk_in, rdy_n, hold_n, byte_pin, pmc_wr, protect_pm, stuck;
  logic              core_valid, dma_valid, core_done, dma_done, addr_oe_n, data_oe_n, ctrl_oe_n;
  logic              rd_n, wr_n, bhe_n, lbs_n, hbs_n, ale, grant_n, bclk_oe_n, plf, wds, bclk_o;
  logic              ale_seen, doe_seen, moved, got;
  logic [3:0]        cs_wait, cs_n, n_wait, cs_acc;
  logic [5:0]        snap;
  logic [7:0]        pmc_wdata, pmc_q;
  logic [15:0]       data_in, rdata, data_out, dout;
  logic [19:0]       addr_out, lat, sa, dur;
  ebc_pkg::ebc_req_s core_req, dma_req;
  int                n_mismatch, total_checks, cyc;

  ebc_top dut (
    .clk(clk), .rstn(rstn), .bclk_in(bclk_in), .rdy_n(rdy_n), .hold_n(hold_n), .byte_pin(byte_pin),
    .data_in(data_in), .pmc_wr(pmc_wr), .pmc_wdata(pmc_wdata), .protect_pm(protect_pm),
    .cs_wait(cs_wait), .pmc_q(pmc_q), .core_valid(core_valid), .core_req(core_req),
    .core_done(core_done), .dma_valid(dma_valid), .dma_req(dma_req), .dma_done(dma_done),
    .rdata(rdata), .addr_out(addr_out), .addr_oe_n(addr_oe_n), .data_out(data_out), .data_oe_n(data_oe_n),
    .rd_n(rd_n), .wr_n(wr_n), .byte_high_enable_n(bhe_n), .low_byte_store_strobe_n(lbs_n),
    .high_byte_store_strobe_n(hbs_n), .cs_n(cs_n), .ctrl_oe_n(ctrl_oe_n), .ale(ale),
    .bus_grant_out_n(grant_n), .bclk_out(bclk_o), .bclk_oe_n(bclk_oe_n), .port_low_float(plf),
    .watchdog_stop(wds));
  ebc_far far (
    .bclk_in(bclk_in), .rdy_n(rdy_n), .data_in(data_in), .rd_n(rd_n), .wr_n(wr_n), .lbs_n(lbs_n),
    .hbs_n(hbs_n), .ale(ale), .cs_n(cs_n), .addr_out(addr_out), .n_wait(n_wait), .stuck(stuck),
    .lat(lat));
  // --------------------------------------------------------------
  // Clock and hang guard
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // A whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [19:0] gv, input logic [19:0] ev);
    total_checks++;
    if (gv !== ev) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, gv, ev);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  function automatic ebc_pkg::ebc_req_s mk(input logic [19:0] a, input logic w, input logic wd,
                                           input logic [1:0] ar, input logic [1:0] cs, input logic mx);
    mk = '{addr: a, wdata: 16'hc3a5, write: w, word: wd, area: ar, cs_idx: cs, mux: mx};
  endfunction : mk
  task automatic setpm(input logic [7:0] v, input logic p);
    @(posedge clk);
    protect_pm <= p;
    pmc_wdata <= v;
    pmc_wr <= 1'b1;
    @(posedge clk);
    pmc_wr <= 1'b0;
    repeat (2) @(negedge clk);
  endtask : setpm
  // One access; records strobe time, first strobe pattern and pin activity
  task automatic run(input ebc_pkg::ebc_req_s r, input logic use_dma);
    dur = 20'h0;
    cs_acc = 4'hf;
    ale_seen = 1'b0;
    doe_seen = 1'b0;
    moved = 1'b0;
    got = 1'b0;
    dout = 16'h0;
    @(posedge clk);
    core_req <= r;
    dma_req <= r;
    core_valid <= !use_dma;
    dma_valid <= use_dma;
    for (int n = 0; n < 400 && !got; n++) begin
      @(negedge clk);
      got = core_done | dma_done;
      cs_acc &= cs_n;
      ale_seen |= ale;
      doe_seen |= !data_oe_n;
      if (!data_oe_n) dout = data_out;
      if (!(rd_n && wr_n && lbs_n && hbs_n)) begin
        if (dur == 20'h0) snap = {rd_n, wr_n, lbs_n, hbs_n, bhe_n, addr_out[0]};
        if (dur == 20'h0) sa = addr_out;
        moved |= (addr_out !== sa);
        dur++;
      end
    end
    @(posedge clk);
    core_valid <= 1'b0;
    dma_valid <= 1'b0;
    chk(got, 20'h1);
  endtask : run
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic s_lanes(input logic split);
    logic w, wd, a0;
    setpm({5'h00, split, 2'h0}, 1'b1);
    chk(pmc_q, {12'h0, 5'h00, split, 2'h0});
    for (int i = 0; i < 8; i++) begin
      if (i == 3 || i == 7) continue;
      w = i[2];
      wd = i[1];
      a0 = i[0];
      run(mk({19'h18008, a0}, w, wd, ebc_pkg::AREA_EXT, 2'h0, 1'b0), 1'b0);
      if (split) chk({snap[5], snap[3:2]}, {w, !(w && (wd || !a0)), !(w && (wd || a0))});
      else chk({snap[5:4], snap[1:0]}, {w, !w, !(wd || a0), a0});
      chk(dur, 20'h8);
      if (!w && wd) chk(rdata, 16'h5a4a);
    end
  endtask : s_lanes
  task automatic s_ready();
    @(posedge clk);
    cs_wait <= 4'he;
    for (int k = 0; k < 6; k += 2) begin
      @(posedge clk);
      n_wait <= 4'(k);
      run(mk(20'h30100, 1'b0, 1'b1, ebc_pkg::AREA_EXT, 2'h0, 1'b0), 1'b0);
      chk(dur, 20'((2 + k) * 8));
      chk(moved, 20'h0);
      chk(rdata, 16'h5b5a);
    end
    @(posedge clk);
    n_wait <= 4'h0;
    stuck <= 1'b1;
    run(mk(20'h28000, 1'b0, 1'b1, ebc_pkg::AREA_EXT, 2'h1, 1'b0), 1'b0);
    chk(dur, 20'h8);
    run(mk(20'h00400, 1'b0, 1'b1, ebc_pkg::AREA_SFR, 2'h0, 1'b0), 1'b1);
    chk(dur, 20'h10);
    @(posedge clk);
    stuck <= 1'b0;
    cs_wait <= 4'hb;
    run(mk(20'h0a124, 1'b0, 1'b1, ebc_pkg::AREA_EXT, 2'h2, 1'b1), 1'b0);
    chk(dur, 20'h18);
    chk(ale_seen, 20'h1);
    chk(lat, 20'h0a124);
  endtask : s_ready
  task automatic s_areas();
    run(mk(20'h29ab0, 1'b1, 1'b0, ebc_pkg::AREA_EXT, 2'h1, 1'b0), 1'b0);
    chk(ale_seen, 20'h0);
    run(mk(20'h01000, 1'b0, 1'b1, ebc_pkg::AREA_INT, 2'h0, 1'b0), 1'b0);
    chk(dur, 20'h0);
    chk({cs_acc, ale_seen}, 5'h1e);
    chk(addr_out, 20'h29ab0);
    run(mk(20'h003e0, 1'b1, 1'b1, ebc_pkg::AREA_SFR, 2'h0, 1'b0), 1'b0);
    chk(dur, 20'h10);
    chk({cs_acc, ale_seen, doe_seen}, 6'h3d);
    chk(dout, 16'hc3a5);
    chk(sa, 20'h003e0);
    @(posedge clk);
    byte_pin <= 1'b1;
    run(mk(20'h28011, 1'b0, 1'b0, ebc_pkg::AREA_EXT, 2'h1, 1'b0), 1'b0);
    chk(snap[5:4], 2'b01);
    @(posedge clk);
    byte_pin <= 1'b0;
  endtask : s_areas
  task automatic s_hold();
    @(posedge clk);
    hold_n <= 1'b0;
    for (int n = 0; n < 40 && grant_n; n++) @(negedge clk);
    @(negedge clk);
    chk({grant_n, addr_oe_n, ctrl_oe_n, plf, wds}, 5'h0f);
    @(posedge clk);
    core_req <= mk(20'h28020, 1'b0, 1'b1, ebc_pkg::AREA_EXT, 2'h1, 1'b0);
    dma_req <= mk(20'h28040, 1'b1, 1'b1, ebc_pkg::AREA_EXT, 2'h1, 1'b0);
    core_valid <= 1'b1;
    dma_valid <= 1'b1;
    got = 1'b0;
    repeat (40) @(negedge clk) got |= core_done | dma_done;
    chk({got, grant_n}, 2'b00);
    @(posedge clk);
    hold_n <= 1'b1;
    for (int n = 0; n < 100 && !(core_done || dma_done); n++) @(negedge clk);
    chk({dma_done, core_done, grant_n}, 3'b101);
    @(posedge clk);
    dma_valid <= 1'b0;
    for (int n = 0; n < 100 && !core_done; n++) @(negedge clk);
    chk(core_done, 20'h1);
    @(posedge clk);
    core_valid <= 1'b0;
  endtask : s_hold
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    hold_n = 1'b1;
    byte_pin = 1'b0;
    pmc_wr = 1'b0;
    pmc_wdata = 8'h00;
    protect_pm = 1'b0;
    cs_wait = 4'hf;
    core_valid = 1'b0;
    dma_valid = 1'b0;
    core_req = '0;
    dma_req = '0;
    n_wait = 4'h0;
    stuck = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({pmc_q, rd_n, wr_n, lbs_n, hbs_n, cs_n, ale, grant_n}, {8'h00, 10'h3fd});
    @(posedge clk);
    rstn <= 1'b1;
    setpm(8'h84, 1'b0);
    chk(pmc_q, 20'h0);
    setpm(8'h84, 1'b1);
    chk({pmc_q, bclk_oe_n}, 9'h109);
    setpm(8'h00, 1'b1);
    chk({pmc_q, bclk_oe_n}, 9'h000);
    // Bus clock copy follows the pin two system clocks late
    @(negedge bclk_in);
    repeat (3) @(negedge clk);
    chk(bclk_o, 20'h0);
    @(posedge bclk_in);
    repeat (3) @(negedge clk);
    chk(bclk_o, 20'h1);
    s_lanes(1'b1);
    s_lanes(1'b0);
    s_ready();
    s_areas();
    s_hold();
    conclude();
  end
endmodule : external_bus_control_tb
`default_nettype wire
